// >>> dv/lss_peer.sv
// Purpose: Far side peer and maintenance unit model
// Assumes: Commands come from the bench
// Notes: Holds reset after three sanity flips
`timescale 1ns/10ps
module lss_peer (
  input wire logic clk,  // Clock
  input wire logic arst_n,  // Reset
  input wire logic fiber_ok,  // Fiber intact
  input wire logic peer_on,  // Peer answers
  input wire logic sane,  // Interface sanity
  input wire logic relay,  // Relay closed
  output logic rx_oof,  // Out of frame
  output logic nbr_ok,  // Neighbor answers
  output logic closure,  // Lead closure
  output logic hold  // Reset hold
);
  logic sane_q;
  logic [1:0] flips_q;
  assign rx_oof = !fiber_ok;
  assign nbr_ok = fiber_ok && peer_on;
  assign closure = relay;
  assign hold = flips_q == 2'h3;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sane_q <= 1'h1;
      flips_q <= 2'h0;
    end else begin
      sane_q <= sane;
      if (sane != sane_q && !hold) flips_q <= flips_q + 2'h1;
    end
  end
endmodule

// >>> dv/lss_top_bench.sv
// Purpose: Self-checking bench for the lamp block
// Assumes: Timebase shortened to ten cycles
// Notes: Peer model drives the fiber pins
`timescale 1ns/10ps
module lss_top_bench;
  import lss_pkg::*;
  localparam int TC = 10;
  logic clk, rst_n, psel, pen, pwr, fib, peer, sane, relay, slip, oos, mup, rup;
  logic oof, nbr, clo, hold, rdy, err, red, grn, yel, sv, lb, len, drop, irq;
  logic [7:0] pa;
  logic [31:0] pwd, prd;
  logic [32:0] rd;
  logic [1:0] mode;
  int num_errors, n_checks;
  lss_top #(.TICK_CYC(TC)) lss_top_inst (.CLK_SYS(clk), .ARST_N(rst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy),
    .PSLVERR(err), .RX_OOF(oof), .NEIGHBOR_OK(nbr), .SLIP_DET(slip), .CLK_OOS(oos),
    .SURV_CLOSURE(clo), .MAIN_LINK_UP(mup), .REMOTE_LINK_UP(rup), .HOLD_RST(hold),
    .LED_RED(red), .LED_GREEN(grn), .LED_YELLOW(yel), .LED_SURVIVE(sv),
    .LOOPBACK_EN(lb), .LINK_EN(len), .LINK_DROP(drop), .MODE(mode), .IRQ(irq));
  lss_peer lss_peer_inst (.clk(clk), .arst_n(rst_n), .fiber_ok(fib), .peer_on(peer),
    .sane(sane), .relay(relay), .rx_oof(oof), .nbr_ok(nbr), .closure(clo), .hold(hold));
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Error flag and read data captured at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (rdy !== 1'h1);
    rd = {err, prd};
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [32:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  // Lengths of one full on phase and off phase
  task automatic meas(input int on_c, input int off_c);
    int h;
    int l;
    h = 0;
    l = 0;
    // Old pattern must leave the lamp first
    cyc(5);
    @(negedge yel);
    @(posedge yel);
    while (yel === 1'h1) begin
      @(posedge clk);
      #1;
      h++;
    end
    while (yel === 1'h0) begin
      @(posedge clk);
      #1;
      l++;
    end
    chk(h, on_c * TC);
    chk(l, off_c * TC);
    @(posedge clk);
  endtask
  task automatic t_lamps;
    int l;
    rdc(8'h14, 33'h100000000);
    rdc(ADDR_CTRL, 33'h0);
    apb(1'h1, ADDR_CTRL, 32'h3);
    cyc(3);
    chk({red, grn, yel}, 3'h6);
    apb(1'h1, ADDR_CTRL, 32'h4);
    cyc(6);
    chk({red, grn}, 2'h0);
    l = 0;
    repeat (300) begin
      @(posedge clk);
      if (yel !== 1'h1) l++;
    end
    chk(l, 0);
    apb(1'h1, ADDR_CTRL, 32'hc);
    meas(ACT_ON_TICKS, ACT_OFF_TICKS);
    $display("t_lamps done");
  endtask
  task automatic t_oof;
    apb(1'h1, ADDR_IRQ_MASK, 32'h1);
    fib <= 1'h0;
    meas(OOF_ON_TICKS, OOF_OFF_TICKS);
    rdc(ADDR_ERR_LOG, 33'h301);
    rdc(ADDR_IRQ_STAT, 33'h1);
    chk(irq, 1'h1);
    apb(1'h1, ADDR_IRQ_STAT, 32'h1);
    cyc(2);
    chk(irq, 1'h0);
    fib <= 1'h1;
    $display("t_oof done");
  endtask
  task automatic t_nn;
    peer <= 1'h0;
    meas(NN_ON_TICKS, NN_OFF_TICKS);
    rdc(ADDR_ERR_LOG, 33'h501);
    peer <= 1'h1;
    apb(1'h1, ADDR_CTRL, 32'h14);
    meas(NN_ON_TICKS, NN_OFF_TICKS);
    chk(len, 1'h0);
    relay <= 1'h1;
    cyc(5);
    chk({sv, lb, len}, 3'h7);
    fib <= 1'h0;
    cyc(3);
    rdc(ADDR_ERR_LOG, 33'h302);
    fib <= 1'h1;
    relay <= 1'h0;
    apb(1'h1, ADDR_IRQ_STAT, 32'h1f);
    $display("t_nn done");
  endtask
  task automatic t_mode;
    for (int i = 0; i < 4; i++) begin
      {mup, rup} <= i[1:0];
      cyc(5);
      chk(mode, i == 0 ? 2'h2 : i == 1 ? 2'h1 : 2'h0);
    end
    $display("t_mode done");
  endtask
  task automatic t_slip_hold;
    slip <= 1'h1;
    cyc(3);
    slip <= 1'h0;
    cyc(5);
    rdc(ADDR_IRQ_STAT, 33'h4);
    chk(irq, 1'h0);
    apb(1'h1, ADDR_CTRL, 32'h24);
    oos <= 1'h1;
    cyc(6);
    chk({drop, len}, 2'h2);
    oos <= 1'h0;
    repeat (3) begin
      sane <= !sane;
      cyc(2);
    end
    cyc(4);
    chk({red, len}, 2'h2);
    $display("t_slip_hold done");
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rst_n, psel, pen, pwr, relay, slip, oos, rup} = 8'h0;
    {fib, peer, sane, mup} = 4'hf;
    pa = 8'h0;
    pwd = 32'h0;
    num_errors = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    t_lamps;
    t_oof;
    t_nn;
    t_mode;
    t_slip_hold;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report;
  end
endmodule

// >>> dv/lss_top_sva.sv
// Purpose: Port assertions for the lamp block
// Assumes: One clock, bound to lss_top
// Notes: Pins reach lamps three edges later, yellow pattern changes four
`timescale 1ns/10ps
module lss_top_sva #(
  parameter int TICK_CYC = 10
) (
  input wire logic CLK_SYS,  // Clock
  input wire logic ARST_N,  // Reset
  input wire logic PSEL,  // Select
  input wire logic PENABLE,  // Enable
  input wire logic PREADY,  // Ready
  input wire logic RX_OOF,  // Out of frame
  input wire logic SURV_CLOSURE,  // Closure
  input wire logic MAIN_LINK_UP,  // Main up
  input wire logic REMOTE_LINK_UP,  // Remote up
  input wire logic HOLD_RST,  // Hold
  input wire logic LED_RED,  // Red
  input wire logic LED_YELLOW,  // Yellow
  input wire logic LED_SURVIVE,  // Survive
  input wire logic LOOPBACK_EN,  // Loopback
  input wire logic LINK_EN,  // Link enable
  input wire logic [1:0] MODE  // Mode
);
  logic yel_q;
  int run_q;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);
  // Cycles of unchanged yellow while out of frame
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      yel_q <= 1'h0;
      run_q <= 0;
    end else begin
      yel_q <= LED_YELLOW;
      run_q <= (LED_YELLOW == yel_q && RX_OOF && !HOLD_RST) ? run_q + 1 : 0;
    end
  end
  property p_red;
    HOLD_RST [*4] |-> LED_RED && !LINK_EN;
  endproperty
  a_red: assert property (p_red) else $error("hold not shown");
  property p_surv;
    SURV_CLOSURE [*4] |-> LED_SURVIVE && LOOPBACK_EN;
  endproperty
  a_surv: assert property (p_surv) else $error("survive missing");
  property p_norm;
    !SURV_CLOSURE [*4] |-> !LED_SURVIVE && !LOOPBACK_EN;
  endproperty
  a_norm: assert property (p_norm) else $error("survive stuck");
  property p_lb;
    $rose(LOOPBACK_EN) |-> $past(SURV_CLOSURE, 3);
  endproperty
  a_lb: assert property (p_lb) else $error("loopback early");
  property p_mode;
    $stable({MAIN_LINK_UP, REMOTE_LINK_UP}) [*5] |->
      MODE == (MAIN_LINK_UP ? 2'h0 : REMOTE_LINK_UP ? 2'h1 : 2'h2);
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_oof;
    RX_OOF [*8] |-> run_q <= TICK_CYC + 4;
  endproperty
  a_oof: assert property (p_oof) else $error("oof blink slow");
  property p_rdy;
    PSEL && !PENABLE |-> ##2 PREADY;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_acc;
    PREADY |-> PSEL && PENABLE ##1 !PREADY;
  endproperty
  a_acc: assert property (p_acc) else $error("ready stray");
endmodule
bind lss_top lss_top_sva #(.TICK_CYC(TICK_CYC)) lss_top_sva_inst (.CLK_SYS(CLK_SYS),
  .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY), .RX_OOF(RX_OOF),
  .SURV_CLOSURE(SURV_CLOSURE), .MAIN_LINK_UP(MAIN_LINK_UP),
  .REMOTE_LINK_UP(REMOTE_LINK_UP), .HOLD_RST(HOLD_RST), .LED_RED(LED_RED),
  .LED_YELLOW(LED_YELLOW), .LED_SURVIVE(LED_SURVIVE), .LOOPBACK_EN(LOOPBACK_EN),
  .LINK_EN(LINK_EN), .MODE(MODE));

// >>> rtl/lss_pkg.sv
// Purpose: Shared constants and types for the link status lamp block
// Assumes: 200 MHz system clock, APB register access
// Notes: Lamp patterns are counted in 100 ms timebase ticks
package lss_pkg;
  // Clock and timebase
  localparam int CLK_MHZ = 200;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_MHZ * 1000 * TICK_MS;
  // Lamp intervals in ms, as printed
  localparam int OOF_ON_MS = 100;
  localparam int OOF_OFF_MS = 100;
  localparam int NN_ON_MS = 500;
  localparam int NN_OFF_MS = 500;
  localparam int ACT_ON_MS = 2000;
  localparam int ACT_OFF_MS = 200;
  // Same intervals in timebase ticks
  localparam int TW = 5;
  localparam logic [TW-1:0] OOF_ON_TICKS = TW'(OOF_ON_MS / TICK_MS);
  localparam logic [TW-1:0] OOF_OFF_TICKS = TW'(OOF_OFF_MS / TICK_MS);
  localparam logic [TW-1:0] NN_ON_TICKS = TW'(NN_ON_MS / TICK_MS);
  localparam logic [TW-1:0] NN_OFF_TICKS = TW'(NN_OFF_MS / TICK_MS);
  localparam logic [TW-1:0] ACT_ON_TICKS = TW'(ACT_ON_MS / TICK_MS);
  localparam logic [TW-1:0] ACT_OFF_TICKS = TW'(ACT_OFF_MS / TICK_MS);
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_ERR_LOG = 8'h10;
  // Control fields
  localparam int CTRL_ALARM = 0;
  localparam int CTRL_TEST = 1;
  localparam int CTRL_ACTIVE = 2;
  localparam int CTRL_MASTER = 3;
  localparam int CTRL_REMOTE = 4;
  localparam int CTRL_DROP_EN = 5;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  // Event fields of status and mask
  localparam int EV_OOF = 0;
  localparam int EV_NN = 1;
  localparam int EV_SLIP = 2;
  localparam int EV_SURV = 3;
  localparam int EV_DROP = 4;
  localparam int EV_W = 5;
  localparam logic [EV_W-1:0] EV_RST = 5'h00;
  // Logged error codes
  localparam logic [10:0] ERR_OOF_LINK = 11'h301;
  localparam logic [10:0] ERR_OOF_LOOP = 11'h302;
  localparam logic [10:0] ERR_NO_NEIGHBOR = 11'h501;
  localparam logic [10:0] ERR_RST = 11'h000;
  // Input pins, synchronised as one vector
  localparam int LNK_W = 8;
  typedef struct packed {
    logic oof;
    logic neighbor;
    logic slip;
    logic clk_oos;
    logic closure;
    logic main_up;
    logic remote_up;
    logic hold;
  } lss_link_type;
  typedef struct packed {
    logic red;
    logic green;
    logic yellow;
    logic survive;
  } lss_lamp_type;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_SURVIVE, MODE_EMERG} lss_mode_type;
  typedef enum logic [2:0] {YEL_OFF, YEL_ON, YEL_OOF, YEL_NN, YEL_ACT} lss_yel_type;
endpackage

// >>> rtl/lss_timebase.sv
// Purpose: Divides the system clock down to the lamp timebase tick
// Assumes: CYCLES of at least 2
// Notes: Tick is a one-cycle pulse every CYCLES clocks
`timescale 1ns/10ps
module lss_timebase #(
  parameter int CYCLES = 20000000
) (
  input wire logic clk,  // System clock
  input wire logic arst_n,  // Async reset, active low
  output logic tick  // One-cycle pulse per period
);
  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic wrap;

  assign wrap = (cnt_q == LAST);
  assign cnt_d = wrap ? '0 : cnt_q + 1'b1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= wrap;
    end
  end
endmodule

// >>> rtl/lss_top.sv
// Purpose: Lamp indication and survive supervision of a fiber link interface
// Assumes: APB slave, one wait state on every access
// Notes: All yellow patterns share one 100 ms timebase
`timescale 1ns/10ps
module lss_top
  import lss_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic CLK_SYS,  // System clock
  input wire logic ARST_N,  // Async reset, active low
  input wire logic PSEL,  // APB select
  input wire logic PENABLE,  // APB enable
  input wire logic PWRITE,  // APB direction
  input wire logic [7:0] PADDR,  // APB byte address
  input wire logic [31:0] PWDATA,  // APB write data
  output logic [31:0] PRDATA,  // APB read data
  output logic PREADY,  // APB ready
  output logic PSLVERR,  // APB error, unmapped address
  input wire logic RX_OOF,  // Fiber receiver out of frame
  input wire logic NEIGHBOR_OK,  // Far end interface answers
  input wire logic SLIP_DET,  // Synchronisation slip seen
  input wire logic CLK_OOS,  // Link clock out of spec
  input wire logic SURV_CLOSURE,  // Survive control lead closed to return
  input wire logic MAIN_LINK_UP,  // Main side link up
  input wire logic REMOTE_LINK_UP,  // Remote side link up
  input wire logic HOLD_RST,  // Maintenance unit holds reset
  output logic LED_RED,  // Red lamp
  output logic LED_GREEN,  // Green lamp
  output logic LED_YELLOW,  // Yellow lamp
  output logic LED_SURVIVE,  // Survive mode lamp
  output logic LOOPBACK_EN,  // Fiber looped back to main side
  output logic LINK_EN,  // Link may come up
  output logic LINK_DROP,  // Link dropped for bad clock
  output logic [1:0] MODE,  // Operating mode
  output logic IRQ  // Level interrupt
);
  // Input synchroniser
  logic [LNK_W-1:0] raw;
  logic [LNK_W-1:0] meta_q;
  logic [LNK_W-1:0] sync_q;
  lss_link_type lnk;
  lss_link_type lnk_prev_q;

  assign raw = {RX_OOF, NEIGHBOR_OK, SLIP_DET, CLK_OOS, SURV_CLOSURE, MAIN_LINK_UP,
                REMOTE_LINK_UP, HOLD_RST};
  assign lnk = lss_link_type'(sync_q);

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      meta_q <= '0;
      sync_q <= '0;
      lnk_prev_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
      lnk_prev_q <= lnk;
    end
  end

  // Registers
  logic [CTRL_W-1:0] ctrl_q;
  logic [EV_W-1:0] ev_stat_q;
  logic [EV_W-1:0] ev_mask_q;
  logic [10:0] err_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // APB decode
  logic setup_acc;
  logic wait_acc;
  logic wr_fire;
  logic hit_ctrl;
  logic hit_status;
  logic hit_stat;
  logic hit_mask;
  logic hit_err;
  logic hit_any;
  logic [31:0] rd_mux;
  logic [31:0] status_word;

  assign setup_acc = PSEL && !PENABLE;
  assign wait_acc = PSEL && PENABLE && !pready_q;
  assign wr_fire = PSEL && PENABLE && pready_q && PWRITE;
  assign hit_ctrl = (PADDR == ADDR_CTRL);
  assign hit_status = (PADDR == ADDR_STATUS);
  assign hit_stat = (PADDR == ADDR_IRQ_STAT);
  assign hit_mask = (PADDR == ADDR_IRQ_MASK);
  assign hit_err = (PADDR == ADDR_ERR_LOG);
  assign hit_any = hit_ctrl || hit_status || hit_stat || hit_mask || hit_err;

  // Control field views
  logic alarm;
  logic test_run;
  logic active;
  logic master;
  logic remote;
  logic drop_en;

  assign alarm = ctrl_q[CTRL_ALARM];
  assign test_run = ctrl_q[CTRL_TEST];
  assign active = ctrl_q[CTRL_ACTIVE];
  assign master = ctrl_q[CTRL_MASTER];
  assign remote = ctrl_q[CTRL_REMOTE];
  assign drop_en = ctrl_q[CTRL_DROP_EN];

  // Mode from the two link states
  lss_mode_type mode_d;
  logic survive;
  logic remote_idle;

  assign mode_d = (!lnk.main_up && lnk.remote_up) ? MODE_SURVIVE :
                  (!lnk.main_up && !lnk.remote_up) ? MODE_EMERG : MODE_NORMAL;
  assign survive = lnk.closure;
  assign remote_idle = remote && !survive;

  // Yellow pattern selection, highest first
  lss_yel_type sel_d;
  lss_yel_type sel_q;
  logic no_neighbor;

  assign no_neighbor = !lnk.neighbor || remote_idle;
  assign sel_d = lnk.oof ? YEL_OOF :
                 no_neighbor ? YEL_NN :
                 !active ? YEL_OFF :
                 master ? YEL_ACT : YEL_ON;

  // Blink phase on the shared timebase
  logic tick;
  logic ph_on_q;
  logic [TW-1:0] ph_cnt_q;
  logic [TW-1:0] ph_cnt_inc;
  logic [TW-1:0] on_len;
  logic [TW-1:0] off_len;
  logic [TW-1:0] cur_len;
  logic ph_end;
  logic yel_d;

  lss_timebase #(
    .CYCLES(TICK_CYC)
  ) u_timebase (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .tick(tick)
  );

  assign on_len = (sel_q == YEL_OOF) ? OOF_ON_TICKS :
                  (sel_q == YEL_NN) ? NN_ON_TICKS : ACT_ON_TICKS;
  assign off_len = (sel_q == YEL_OOF) ? OOF_OFF_TICKS :
                   (sel_q == YEL_NN) ? NN_OFF_TICKS : ACT_OFF_TICKS;
  assign cur_len = ph_on_q ? on_len : off_len;
  assign ph_cnt_inc = ph_cnt_q + 1'b1;
  assign ph_end = tick && (ph_cnt_inc >= cur_len);

  always_comb begin
    case (sel_q)
      YEL_OFF: yel_d = 1'b0;
      YEL_ON: yel_d = 1'b1;
      YEL_OOF: yel_d = ph_on_q;
      YEL_NN: yel_d = ph_on_q;
      YEL_ACT: yel_d = ph_on_q;
      default: yel_d = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_q <= YEL_OFF;
      ph_on_q <= 1'b1;
      ph_cnt_q <= '0;
    end else begin
      sel_q <= sel_d;
      if (sel_d != sel_q) begin
        ph_on_q <= 1'b1;
        ph_cnt_q <= '0;
      end else if (ph_end) begin
        ph_on_q <= !ph_on_q;
        ph_cnt_q <= '0;
      end else if (tick) begin
        ph_cnt_q <= ph_cnt_inc;
      end
    end
  end

  // Events
  logic oof_rise;
  logic nn_now;
  logic nn_prev;
  logic nn_rise;
  logic drop_now;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  assign oof_rise = lnk.oof && !lnk_prev_q.oof;
  assign nn_now = !lnk.oof && !lnk.neighbor;
  assign nn_prev = !lnk_prev_q.oof && !lnk_prev_q.neighbor;
  assign nn_rise = nn_now && !nn_prev;
  assign drop_now = drop_en && lnk.clk_oos;
  assign ev_set[EV_OOF] = oof_rise;
  assign ev_set[EV_NN] = nn_rise;
  assign ev_set[EV_SLIP] = lnk.slip && !lnk_prev_q.slip;
  assign ev_set[EV_SURV] = lnk.closure && !lnk_prev_q.closure;
  assign ev_set[EV_DROP] = drop_now && !LINK_DROP;
  assign ev_clr = (wr_fire && hit_stat) ? PWDATA[EV_W-1:0] : '0;

  // Status word
  assign status_word = {18'h00000, mode_d, sel_q, LINK_EN, LOOPBACK_EN, lnk.hold,
                        lnk.neighbor, lnk.oof, LED_SURVIVE, LED_YELLOW, LED_GREEN, LED_RED};
  assign rd_mux = hit_ctrl ? {26'h0000000, ctrl_q} :
                  hit_status ? status_word :
                  hit_stat ? {27'h0000000, ev_stat_q} :
                  hit_mask ? {27'h0000000, ev_mask_q} :
                  hit_err ? {21'h000000, err_q} : 32'h00000000;

  // APB slave
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= wait_acc;
      pslverr_q <= wait_acc && !hit_any;
      if (wait_acc && !PWRITE) begin
        prdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= CTRL_RST;
      ev_mask_q <= EV_RST;
      ev_stat_q <= EV_RST;
    end else begin
      if (wr_fire && hit_ctrl) begin
        ctrl_q <= PWDATA[CTRL_W-1:0];
      end
      if (wr_fire && hit_mask) begin
        ev_mask_q <= PWDATA[EV_W-1:0];
      end
      ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
    end
  end

  // Error log, last condition seen
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      err_q <= ERR_RST;
    end else if (oof_rise) begin
      err_q <= survive ? ERR_OOF_LOOP : ERR_OOF_LINK;
    end else if (nn_rise) begin
      err_q <= ERR_NO_NEIGHBOR;
    end
  end

  // Registered outputs
  lss_lamp_type lamp_d;

  assign lamp_d.red = alarm || lnk.hold;
  assign lamp_d.green = test_run;
  assign lamp_d.yellow = yel_d && !lnk.hold;
  assign lamp_d.survive = survive;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      LED_RED <= 1'b0;
      LED_GREEN <= 1'b0;
      LED_YELLOW <= 1'b0;
      LED_SURVIVE <= 1'b0;
      LOOPBACK_EN <= 1'b0;
      LINK_EN <= 1'b0;
      LINK_DROP <= 1'b0;
      MODE <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      LED_RED <= lamp_d.red;
      LED_GREEN <= lamp_d.green;
      LED_YELLOW <= lamp_d.yellow;
      LED_SURVIVE <= lamp_d.survive;
      LOOPBACK_EN <= survive;
      LINK_EN <= !lnk.hold && !remote_idle && !drop_now;
      LINK_DROP <= drop_now;
      MODE <= mode_d;
      IRQ <= |(ev_stat_q & ev_mask_q);
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
endmodule
